// ==== dmic_consts.vh ====
/*
  Constants for the direct-mapped instruction cache: register offsets,
  control and region field positions, reset values, external size codes.
  Assumes inclusion by bare name from the design files.
*/
`ifndef DMIC_CONSTS_VH
`define DMIC_CONSTS_VH

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define DMIC_ADR_W        8
`define DMIC_OFS_CTL      8'h00
`define DMIC_OFS_RG0      8'h04
`define DMIC_OFS_RG1      8'h08
`define DMIC_OFS_STAT     8'h0C

// ****************************************************************
// control register fields
// ****************************************************************
`define DMIC_CTL_EN       31
`define DMIC_CTL_NOLINV   28
`define DMIC_CTL_FRZ      27
`define DMIC_CTL_INV      24
`define DMIC_CTL_BURST    10
`define DMIC_CTL_NC       9
`define DMIC_CTL_BUFW     8
`define DMIC_CTL_WP       5
`define DMIC_CTL_FS_HI    1
`define DMIC_CTL_FS_LO    0
`define DMIC_CTL_WMASK    32'h9800_0723
`define DMIC_CTL_RST      32'h0000_0000

// ****************************************************************
// region register fields
// ****************************************************************
`define DMIC_RG_BASE_HI   31
`define DMIC_RG_BASE_LO   24
`define DMIC_RG_MASK_HI   23
`define DMIC_RG_MASK_LO   16
`define DMIC_RG_EN        15
`define DMIC_RG_WMASK     32'hFFFF_8320
`define DMIC_RG_RST       32'h0000_0000

// ****************************************************************
// address fields
// ****************************************************************
`define DMIC_TAG_HI       31
`define DMIC_TAG_LO       9
`define DMIC_IDX_HI       8
`define DMIC_IDX_LO       4
`define DMIC_WIDX_LO      2
`define DMIC_OFF_HI       3
`define DMIC_OFF_LO       2
`define DMIC_HALF_BIT     1

// ****************************************************************
// external size codes and fill-size encodings
// ****************************************************************
`define DMIC_SZ_LONG      2'h0
`define DMIC_SZ_WORD      2'h2
`define DMIC_SZ_LINE      2'h3
`define DMIC_FS_LINE_X3   2'h0
`define DMIC_FS_LINE_LO   2'h1
`define DMIC_OFF_LAST     2'h3
`define DMIC_BEATS_LINE   3'h4
`define DMIC_BEATS_ONE    3'h1

`endif

// ==== dmic_region_match.v ====
/*
  Effective attribute selection for one reference: region register 0,
  then region register 1, else the control register defaults.
  Assumes all inputs are steady, same-clock register outputs.
*/
`timescale 1ns/10ps
`include "dmic_consts.vh"

module dmic_region_match (
  input  wire [31:0] ref_addr,
  input  wire [31:0] ctl_val,
  input  wire [31:0] rg0_val,
  input  wire [31:0] rg1_val,
  output reg         eff_nc,
  output reg         eff_bufw,
  output reg         eff_wp
);

  // ****************************************************************
  // masked base compare
  // ****************************************************************
  wire [7:0] ref_hi = ref_addr[`DMIC_RG_BASE_HI:`DMIC_RG_BASE_LO];
  wire       hit0   = rg0_val[`DMIC_RG_EN] &&
                      (((ref_hi ^ rg0_val[`DMIC_RG_BASE_HI:`DMIC_RG_BASE_LO]) &
                        ~rg0_val[`DMIC_RG_MASK_HI:`DMIC_RG_MASK_LO]) == 8'h00);
  wire       hit1   = rg1_val[`DMIC_RG_EN] &&
                      (((ref_hi ^ rg1_val[`DMIC_RG_BASE_HI:`DMIC_RG_BASE_LO]) &
                        ~rg1_val[`DMIC_RG_MASK_HI:`DMIC_RG_MASK_LO]) == 8'h00);
  reg [31:0] src;

  // ****************************************************************
  // priority select
  // ****************************************************************
  always @* begin
    if (hit0) begin
      src = rg0_val;
    end else if (hit1) begin
      src = rg1_val;
    end else begin
      src = ctl_val;
    end
    eff_nc   = src[`DMIC_CTL_NC];
    eff_bufw = src[`DMIC_CTL_BUFW];
    eff_wp   = src[`DMIC_CTL_WP];
  end

endmodule // dmic_region_match

// ==== dmic_cache.v ====
/*
  Direct-mapped 512-byte instruction cache: tag and data arrays, line
  fill buffer, nonblocking miss engine, invalidation, Wishbone registers.
  Assumes the fetch master holds its request until fetch_ack, the
  external controller answers each beat with one ext_ack pulse, and all
  ports are on mclk.
*/
`timescale 1ns/10ps
`include "dmic_consts.vh"

module dmic_cache #(
  parameter LINES = 32,
  parameter WORDS = 4
) (
  input  wire        mclk,
  input  wire        srst,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        fetch_req,
  input  wire [31:0] fetch_addr,
  input  wire        fetch_sram,
  output reg         fetch_ack,
  output reg  [31:0] fetch_data,
  output reg         fetch_bufw,
  output reg         fetch_wprot,
  input  wire        core_linv_req,
  input  wire [31:0] core_linv_addr,
  input  wire        dbg_linv_req,
  input  wire [31:0] dbg_linv_addr,
  input  wire        dbg_full_inv_req,
  output wire        ext_req,
  output wire [31:0] ext_addr,
  output wire [1:0]  ext_size,
  input  wire        ext_ack,
  input  wire [31:0] ext_rdata
);

  localparam IW = 5;
  localparam TW = 23;
  localparam FTW = 28;

  // ****************************************************************
  // storage
  // ****************************************************************
  reg [31:0]     cache_control_reg;
  reg [31:0]     region_attr_reg_zero;
  reg [31:0]     region_attr_reg_one;
  reg [TW-1:0]   tag_addr_reg [0:LINES-1];
  reg [LINES-1:0] tag_vld_reg;
  reg [31:0]     data_reg [0:LINES*WORDS-1];
  reg [FTW-1:0]  fb_tag_reg;
  reg [WORDS-1:0] fb_wv_reg;
  reg [31:0]     fb_data_reg [0:WORDS-1];
  reg            fb_live_reg;
  reg            fb_cach_reg;
  reg            fb_mru_reg;
  reg            inv_busy_reg;
  reg [IW-1:0]   inv_idx_reg;
  reg            fill_busy_reg;
  reg [31:0]     fill_addr_reg;
  reg [2:0]      fill_left_reg;
  reg [1:0]      fill_size_reg;
  reg            fill_to_fb_reg;
  reg            pend_reg;
  integer        k;

  // ****************************************************************
  // attributes
  // ****************************************************************
  wire eff_nc;
  wire eff_bufw;
  wire eff_wp;

  dmic_region_match u_match (
    .ref_addr (fetch_addr),
    .ctl_val  (cache_control_reg),
    .rg0_val  (region_attr_reg_zero),
    .rg1_val  (region_attr_reg_one),
    .eff_nc   (eff_nc),
    .eff_bufw (eff_bufw),
    .eff_wp   (eff_wp)
  );

  // ****************************************************************
  // lookup
  // ****************************************************************
  wire [IW-1:0] f_idx  = fetch_addr[`DMIC_IDX_HI:`DMIC_IDX_LO];
  wire [6:0]    f_widx = fetch_addr[`DMIC_IDX_HI:`DMIC_WIDX_LO];
  wire [1:0]    f_off  = fetch_addr[`DMIC_OFF_HI:`DMIC_OFF_LO];
  wire [1:0]    fs     = cache_control_reg[`DMIC_CTL_FS_HI:`DMIC_CTL_FS_LO];
  wire          en     = cache_control_reg[`DMIC_CTL_EN];
  wire          burst  = cache_control_reg[`DMIC_CTL_BURST];
  wire          arr_hit = tag_vld_reg[f_idx] &&
                          (tag_addr_reg[f_idx] == fetch_addr[`DMIC_TAG_HI:`DMIC_TAG_LO]);
  wire          fb_hit = fb_live_reg && (fb_tag_reg == fetch_addr[31:`DMIC_OFF_HI+1]) &&
                         fb_wv_reg[f_off];
  wire          take   = fetch_req && !fetch_ack && !inv_busy_reg && !pend_reg
                         && !fetch_sram;
  wire          serve_fb  = take && en && fb_hit;
  wire          serve_arr = take && en && !eff_nc && !fb_hit && arr_hit;
  wire          start_miss = take && !serve_fb && !serve_arr && !fill_busy_reg;
  wire          use_fb = en && (!eff_nc || burst);
  reg           is_line;

  always @* begin
    if (fs == `DMIC_FS_LINE_X3) begin
      is_line = (f_off != `DMIC_OFF_LAST);
    end else if (fs == `DMIC_FS_LINE_LO) begin
      is_line = !f_off[1];
    end else begin
      is_line = 1'b1;
    end
  end

  wire          miss_line = use_fb && is_line;
  wire [IW-1:0] fb_idx    = fb_tag_reg[IW-1:0];
  wire          copy_fb   = start_miss && en && fb_live_reg && fb_cach_reg &&
                            (&fb_wv_reg) && fb_mru_reg &&
                            (!cache_control_reg[`DMIC_CTL_FRZ] ||
                             !tag_vld_reg[fb_idx]);
  wire [1:0]    miss_size = !en ? (fetch_addr[`DMIC_HALF_BIT] ? `DMIC_SZ_WORD :
                                   `DMIC_SZ_LONG) :
                            (miss_line ? `DMIC_SZ_LINE : `DMIC_SZ_LONG);

  // ****************************************************************
  // external request
  // ****************************************************************
  assign ext_req  = fill_busy_reg;
  assign ext_addr = fill_addr_reg;
  assign ext_size = fill_size_reg;

  wire beat = fill_busy_reg && ext_ack;

  // ****************************************************************
  // register bus
  // ****************************************************************
  wire        wb_go = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire        wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  wire [31:0] bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                       {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire        inv_kick = (wb_wr && (wb_adr_i == `DMIC_OFS_CTL) && wb_sel_i[3] &&
                          wb_dat_i[`DMIC_CTL_INV]) || dbg_full_inv_req;
  wire [31:0] status = {24'h000000, inv_busy_reg, fill_busy_reg, pend_reg,
                        fb_mru_reg, fb_live_reg, fb_cach_reg, 2'h0} |
                       {28'h0000000, fb_wv_reg};

  always @(posedge mclk) begin
    if (srst) begin
      cache_control_reg    <= `DMIC_CTL_RST;
      region_attr_reg_zero <= `DMIC_RG_RST;
      region_attr_reg_one  <= `DMIC_RG_RST;
      wb_ack_o             <= 1'b0;
      wb_dat_o             <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_go;
      if (wb_wr) begin
        if (wb_adr_i == `DMIC_OFS_CTL) begin
          cache_control_reg <= (cache_control_reg & ~(bmask & `DMIC_CTL_WMASK)) |
                               (wb_dat_i & bmask & `DMIC_CTL_WMASK);
        end else if (wb_adr_i == `DMIC_OFS_RG0) begin
          region_attr_reg_zero <= (region_attr_reg_zero & ~(bmask & `DMIC_RG_WMASK)) |
                                  (wb_dat_i & bmask & `DMIC_RG_WMASK);
        end else if (wb_adr_i == `DMIC_OFS_RG1) begin
          region_attr_reg_one <= (region_attr_reg_one & ~(bmask & `DMIC_RG_WMASK)) |
                                 (wb_dat_i & bmask & `DMIC_RG_WMASK);
        end
      end
      if (wb_go && !wb_we_i) begin
        if (wb_adr_i == `DMIC_OFS_CTL) begin
          wb_dat_o <= cache_control_reg;
        end else if (wb_adr_i == `DMIC_OFS_RG0) begin
          wb_dat_o <= region_attr_reg_zero;
        end else if (wb_adr_i == `DMIC_OFS_RG1) begin
          wb_dat_o <= region_attr_reg_one;
        end else if (wb_adr_i == `DMIC_OFS_STAT) begin
          wb_dat_o <= status;
        end else begin
          wb_dat_o <= 32'h0000_0000;
        end
      end
    end
  end

  // ****************************************************************
  // invalidation sequencer
  // ****************************************************************
  always @(posedge mclk) begin
    if (srst) begin
      inv_busy_reg <= 1'b0;
      inv_idx_reg  <= {IW{1'b0}};
    end else if (inv_busy_reg) begin
      inv_idx_reg <= inv_idx_reg + 1'b1;
      if (inv_idx_reg == LINES[IW-1:0] - 1'b1) begin
        inv_busy_reg <= 1'b0;
      end
    end else if (inv_kick) begin
      inv_busy_reg <= 1'b1;
      inv_idx_reg  <= {IW{1'b0}};
    end
  end

  // ****************************************************************
  // tag valid bits, no reset: contents survive reset
  // ****************************************************************
  always @(posedge mclk) begin
    if (copy_fb) begin
      tag_vld_reg[fb_idx] <= 1'b1;
    end
    if (!cache_control_reg[`DMIC_CTL_NOLINV]) begin
      if (core_linv_req) begin
        tag_vld_reg[core_linv_addr[`DMIC_IDX_HI:`DMIC_IDX_LO]] <= 1'b0;
      end
      if (dbg_linv_req) begin
        tag_vld_reg[dbg_linv_addr[`DMIC_IDX_HI:`DMIC_IDX_LO]] <= 1'b0;
      end
    end
    if (inv_busy_reg) begin
      tag_vld_reg[inv_idx_reg] <= 1'b0;
    end
  end

  // ****************************************************************
  // array load from fill buffer
  // ****************************************************************
  always @(posedge mclk) begin
    if (copy_fb) begin
      tag_addr_reg[fb_idx] <= fb_tag_reg[FTW-1:IW];
      for (k = 0; k < WORDS; k = k + 1) begin
        data_reg[{fb_idx, k[1:0]}] <= fb_data_reg[k];
      end
    end
  end

  // ****************************************************************
  // miss engine
  // ****************************************************************
  always @(posedge mclk) begin
    if (srst) begin
      fill_busy_reg  <= 1'b0;
      fill_addr_reg  <= 32'h0000_0000;
      fill_left_reg  <= 3'h0;
      fill_size_reg  <= `DMIC_SZ_LONG;
      fill_to_fb_reg <= 1'b0;
      pend_reg       <= 1'b0;
    end else if (start_miss) begin
      fill_busy_reg  <= 1'b1;
      pend_reg       <= 1'b1;
      fill_addr_reg  <= {fetch_addr[31:`DMIC_WIDX_LO],
                         (miss_size == `DMIC_SZ_WORD) & fetch_addr[`DMIC_HALF_BIT],
                         1'b0};
      fill_left_reg  <= miss_line ? `DMIC_BEATS_LINE : `DMIC_BEATS_ONE;
      fill_size_reg  <= miss_size;
      fill_to_fb_reg <= miss_line;
    end else if (beat) begin
      pend_reg      <= 1'b0;
      fill_left_reg <= fill_left_reg - 1'b1;
      fill_addr_reg <= {fill_addr_reg[31:`DMIC_OFF_HI+1],
                        fill_addr_reg[`DMIC_OFF_HI:`DMIC_OFF_LO] + 2'h1, 2'h0};
      if (fill_left_reg == `DMIC_BEATS_ONE) begin
        fill_busy_reg <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // fill buffer
  // ****************************************************************
  always @(posedge mclk) begin
    if (srst) begin
      fb_tag_reg  <= {FTW{1'b0}};
      fb_wv_reg   <= {WORDS{1'b0}};
      fb_live_reg <= 1'b0;
      fb_cach_reg <= 1'b0;
      fb_mru_reg  <= 1'b0;
    end else begin
      if (start_miss && miss_line) begin
        fb_tag_reg  <= fetch_addr[31:`DMIC_OFF_HI+1];
        fb_wv_reg   <= {WORDS{1'b0}};
        fb_live_reg <= 1'b1;
        fb_cach_reg <= !eff_nc;
        fb_mru_reg  <= 1'b1;
      end else begin
        if (copy_fb) begin
          fb_mru_reg <= 1'b0;
        end else if (serve_arr && (f_idx == fb_idx)) begin
          fb_mru_reg <= 1'b0;
        end
        if (beat && fill_to_fb_reg) begin
          fb_wv_reg[fill_addr_reg[`DMIC_OFF_HI:`DMIC_OFF_LO]] <= 1'b1;
        end
      end
    end
  end

  always @(posedge mclk) begin
    if (beat && fill_to_fb_reg) begin
      fb_data_reg[fill_addr_reg[`DMIC_OFF_HI:`DMIC_OFF_LO]] <= ext_rdata;
    end
  end

  // ****************************************************************
  // fetch answer
  // ****************************************************************
  always @(posedge mclk) begin
    if (srst) begin
      fetch_ack   <= 1'b0;
      fetch_data  <= 32'h0000_0000;
      fetch_bufw  <= 1'b0;
      fetch_wprot <= 1'b0;
    end else begin
      fetch_ack <= serve_fb || serve_arr || (beat && pend_reg);
      if (serve_fb) begin
        fetch_data <= fb_data_reg[f_off];
      end else if (serve_arr) begin
        fetch_data <= data_reg[f_widx];
      end else if (beat && pend_reg) begin
        fetch_data <= ext_rdata;
      end
      if (take) begin
        fetch_bufw  <= eff_bufw;
        fetch_wprot <= eff_wp;
      end
    end
  end

endmodule // dmic_cache

// ==== dmic_ext_model.sv ====
/*
  External bus controller model: answers each beat with one ack pulse
  after a programmable lag; data is the beat address xor a fixed pattern.
  Assumes the cache holds ext_req and ext_addr until ext_ack.
*/
`timescale 1ns/10ps

module dmic_ext_model (
  input  wire        mclk,
  input  wire        srst,
  input  wire [3:0]  lag,
  input  wire        ext_req,
  input  wire [31:0] ext_addr,
  output reg         ext_ack,
  output reg  [31:0] ext_rdata
);
  reg [3:0] wait_reg;

  // released data bus toggles so stale values never look valid
  always @(posedge mclk) begin
    if (srst) begin
      ext_ack   <= 1'b0;
      wait_reg  <= 4'h0;
      ext_rdata <= 32'h0000_0000;
    end else if (ext_ack) begin
      ext_ack   <= 1'b0;
      wait_reg  <= 4'h0;
      ext_rdata <= ~ext_rdata;
    end else if (ext_req && wait_reg >= lag) begin
      ext_ack   <= 1'b1;
      ext_rdata <= ext_addr ^ 32'h5A00_00F0;
    end else begin
      wait_reg  <= ext_req ? wait_reg + 4'h1 : 4'h0;
      ext_rdata <= ~ext_rdata;
    end
  end
endmodule // dmic_ext_model

// ==== dmic_cache_monitor.sv ====
/*
  Port checker for the instruction cache: fetch answers, external beat
  order and sizes, invalidation stall, reset quiet state.
  Assumes binding to dmic_cache, one clock, synchronous reset.
*/
`timescale 1ns/10ps
`include "dmic_consts.vh"

module dmic_cache_monitor (
  input wire        mclk,
  input wire        srst,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [7:0]  wb_adr_i,
  input wire [3:0]  wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire        wb_ack_o,
  input wire        fetch_req,
  input wire        fetch_sram,
  input wire        fetch_ack,
  input wire [31:0] fetch_data,
  input wire        ext_req,
  input wire [31:0] ext_addr,
  input wire [1:0]  ext_size,
  input wire        ext_ack,
  input wire [31:0] ext_rdata
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  // ****************************************************************
  // shadow of enable bit and beat position
  // ****************************************************************
  reg       en_reg;
  reg [1:0] beat_reg;
  wire      ctl_wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i
                     && wb_adr_i == `DMIC_OFS_CTL && wb_sel_i[3];

  always @(posedge mclk) begin
    if (srst) begin
      en_reg   <= 1'b0;
      beat_reg <= 2'h0;
    end else begin
      if (ctl_wr)
        en_reg <= wb_dat_i[`DMIC_CTL_EN];
      if (ext_req && ext_ack)
        beat_reg <= (ext_size != `DMIC_SZ_LINE || beat_reg == 2'h3) ? 2'h0 : beat_reg + 2'h1;
    end
  end

  // ****************************************************************
  // properties
  // ****************************************************************
  property p_fetch_pulse;
    fetch_ack |=> !fetch_ack;
  endproperty
  a_fetch_pulse: assert property (p_fetch_pulse)
    else $error("fetch ack longer than one cycle");

  property p_first_beat;
    ext_req && ext_ack && beat_reg == 2'h0 |=> fetch_ack && fetch_data == $past(ext_rdata);
  endproperty
  a_first_beat: assert property (p_first_beat)
    else $error("critical beat not passed on next cycle");

  property p_wrap;
    ext_req && ext_ack && ext_size == `DMIC_SZ_LINE && beat_reg != 2'h3 |=>
      ext_addr[31:4] == $past(ext_addr[31:4]) && ext_addr[3:2] == $past(ext_addr[3:2]) + 2'h1;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("line beat address not wrapping");

  property p_hold;
    ext_req && !ext_ack |=> ext_req && $stable(ext_addr) && $stable(ext_size);
  endproperty
  a_hold: assert property (p_hold)
    else $error("external request changed before ack");

  property p_off_size;
    ext_req && !en_reg |-> ext_size == (ext_addr[1] ? `DMIC_SZ_WORD : `DMIC_SZ_LONG);
  endproperty
  a_off_size: assert property (p_off_size)
    else $error("disabled cache used wrong fetch size");

  property p_sram;
    fetch_req && fetch_sram && !ext_req && !fetch_ack |=> !fetch_ack && !ext_req;
  endproperty
  a_sram: assert property (p_sram)
    else $error("sram fetch answered or sent out");

  property p_inv_stall;
    ctl_wr && wb_dat_i[`DMIC_CTL_INV] |-> ##2 !fetch_ack [*8];
  endproperty
  a_inv_stall: assert property (p_inv_stall)
    else $error("fetch answered during invalidation");

  property p_rst;
    disable iff (1'b0) srst |=> !fetch_ack && !ext_req && !wb_ack_o && ext_size == 2'h0;
  endproperty
  a_rst: assert property (p_rst)
    else $error("outputs active after reset");
endmodule // dmic_cache_monitor

bind dmic_cache dmic_cache_monitor mon (.mclk, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_sel_i, .wb_dat_i, .wb_ack_o, .fetch_req, .fetch_sram, .fetch_ack, .fetch_data, .ext_req,
  .ext_addr, .ext_size, .ext_ack, .ext_rdata);

// ==== direct_mapped_instruction_cache_bench.sv ====
/*
  Self-checking bench for the instruction cache with the bus model.
  Assumes the hand-over timing: one-cycle hits, beats held until ack.
*/
`timescale 1ns/10ps
`include "dmic_consts.vh"

module direct_mapped_instruction_cache_bench;
  reg         mclk = 1'b0;
  reg         srst = 1'b1;
  reg         cyc, stb, we, freq, fsram, clinv, dlinv, dfull;
  reg  [7:0]  adr;
  reg  [3:0]  sel, lag;
  reg  [31:0] wdat, faddr, laddr, rv;
  wire        ack, fack, fbufw, fwp, ereq, eack;
  wire [31:0] rdat, fdat, eaddr, erd;
  wire [1:0]  esize;
  reg  [31:0] elog [0:7];
  reg  [1:0]  slog [0:7];
  reg  [1:0]  wp;
  integer     err_total = 0, compares = 0, cycles = 0, n = 0, lat;

  dmic_cache dut (.mclk(mclk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .fetch_req(freq), .fetch_addr(faddr), .fetch_sram(fsram), .fetch_ack(fack),
    .fetch_data(fdat), .fetch_bufw(fbufw), .fetch_wprot(fwp), .core_linv_req(clinv),
    .core_linv_addr(laddr), .dbg_linv_req(dlinv), .dbg_linv_addr(laddr),
    .dbg_full_inv_req(dfull), .ext_req(ereq), .ext_addr(eaddr), .ext_size(esize),
    .ext_ack(eack), .ext_rdata(erd));
  dmic_ext_model ext (.mclk(mclk), .srst(srst), .lag(lag), .ext_req(ereq), .ext_addr(eaddr),
    .ext_ack(eack), .ext_rdata(erd));

  always #2 mclk = ~mclk;

  always @(posedge mclk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      err_total = err_total + 1;
      end_sim;
    end
    if (ereq && eack && n < 8) begin
      elog[n] = eaddr;
      slog[n] = esize;
      n = n + 1;
    end
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  function [31:0] pat(input [31:0] a);
    pat = a ^ 32'h5A00_00F0;
  endfunction

  task check(input [31:0] seen, input [31:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask

  task wb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge mclk);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
      @(posedge mclk);
      while (ack !== 1'b1) @(posedge mclk);
      rv = rdat;
      cyc <= 1'b0; stb <= 1'b0;
    end
  endtask

  task fetch(input [31:0] a, input s, input integer lim);
    integer k;
    begin
      @(posedge mclk);
      freq <= 1'b1; faddr <= a; fsram <= s; n = 0; k = 0;
      @(posedge mclk);
      while (fack !== 1'b1 && k < lim) begin @(posedge mclk); k = k + 1; end
      lat = k; rv = fdat; wp = {fbufw, fwp};
      freq <= 1'b0; fsram <= 1'b0;
    end
  endtask

  task settle;
    integer k;
    begin
      k = 0;
      repeat (2) @(posedge mclk);
      while (ereq !== 1'b0 && k < 200) begin @(posedge mclk); k = k + 1; end
      @(posedge mclk);
    end
  endtask

  task chk_miss(input [31:0] a, input integer beats);
    integer i;
    begin
      fetch(a, 1'b0, 100);
      settle;
      check(n, beats);
      check(rv, pat(a));
      for (i = 0; i < beats; i = i + 1) begin
        check(elog[i], {a[31:4], a[3:2] + i[1:0], 2'h0});
        check(slog[i], beats == 4 ? `DMIC_SZ_LINE : `DMIC_SZ_LONG);
      end
    end
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task t_off;
    begin
      wb(1'b0, `DMIC_OFS_CTL, 32'h0);
      check(rv, `DMIC_CTL_RST);
      fetch(32'h0000_2002, 1'b0, 100); settle;
      check(slog[0], `DMIC_SZ_WORD);
      check(elog[0], 32'h0000_2002);
      check(rv, pat(elog[0]));
      fetch(32'h0000_2000, 1'b0, 100); settle;
      check(slog[0], `DMIC_SZ_LONG);
      fetch(32'h0000_2000, 1'b0, 100); settle;
      check(n, 1);
    end
  endtask

  task t_inv;
    begin
      wb(1'b1, `DMIC_OFS_CTL, 32'h0100_0000);
      fetch(32'h0000_2000, 1'b0, 100); settle;
      check(lat >= 31, 1);
      wb(1'b0, `DMIC_OFS_CTL, 32'h0);
      check(rv, 32'h0);
      @(posedge mclk) dfull <= 1'b1;
      @(posedge mclk) dfull <= 1'b0;
      fetch(32'h0000_2000, 1'b0, 100); settle;
      check(lat >= 30, 1);
    end
  endtask

  task t_sizes;
    integer fs, off;
    begin
      for (fs = 0; fs < 4; fs = fs + 1)
        for (off = 0; off < 4; off = off + 1) begin
          wb(1'b1, `DMIC_OFS_CTL, 32'h8000_0000 | fs);
          chk_miss(32'h0001_0000 | ((fs * 4 + off) << 4) | (off << 2),
                   ((fs == 0 && off == 3) || (fs == 1 && off >= 2)) ? 1 : 4);
        end
    end
  endtask

  task t_buffer;
    begin
      lag = 4'h6;
      wb(1'b1, `DMIC_OFS_CTL, 32'h8000_0002);
      fetch(32'h0003_0208, 1'b0, 100);
      fetch(32'h0003_0208, 1'b0, 100);
      check(lat, 1);
      check(ereq, 1);
      settle;
      fetch(32'h0003_020C, 1'b0, 100);
      check(lat, 1);
      check(rv, pat(32'h0003_020C));
      lag = 4'h0;
      chk_miss(32'h0003_0240, 4);
      fetch(32'h0001_0040, 1'b0, 100);
      check(lat, 1);
      check(rv, pat(32'h0001_0040));
      fetch(32'h0003_0200, 1'b0, 100); settle;
      check(lat, 1);
      check(n, 0);
      check(rv, pat(32'h0003_0200));
    end
  endtask

  task t_linv;
    begin
      wb(1'b1, `DMIC_OFS_CTL, 32'h9000_0002);
      @(posedge mclk) begin dlinv <= 1'b1; laddr <= 32'h0000_0200; end
      @(posedge mclk) dlinv <= 1'b0;
      fetch(32'h0003_0204, 1'b0, 100); settle;
      check(n, 0);
      wb(1'b1, `DMIC_OFS_CTL, 32'h8000_0002);
      @(posedge mclk) clinv <= 1'b1;
      @(posedge mclk) clinv <= 1'b0;
      chk_miss(32'h0003_0204, 4);
      chk_miss(32'h0003_0240, 4);
    end
  endtask

  task t_nc;
    begin
      fetch(32'h0005_0000, 1'b1, 8); settle;
      check(lat, 8);
      check(n, 0);
      wb(1'b1, `DMIC_OFS_CTL, 32'h8000_0202);
      chk_miss(32'h0004_0080, 1);
      chk_miss(32'h0004_0080, 1);
      wb(1'b1, `DMIC_OFS_CTL, 32'h8000_0602);
      chk_miss(32'h0004_0080, 4);
      fetch(32'h0004_0084, 1'b0, 100); settle;
      check(n, 0);
    end
  endtask

  task t_region;
    begin
      wb(1'b1, `DMIC_OFS_RG0, 32'h0000_8120);
      wb(1'b1, `DMIC_OFS_RG1, 32'h00FF_8200);
      chk_miss(32'h0006_0300, 4);
      check(wp, 2'h3);
      chk_miss(32'h0106_0300, 4);
      check(wp, 2'h0);
    end
  endtask

  task end_sim;
    begin
      if (err_total == 0 && compares > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask

  initial begin
    cyc = 0; stb = 0; we = 0; adr = 0; sel = 0; wdat = 0; freq = 0; faddr = 0;
    fsram = 0; clinv = 0; dlinv = 0; dfull = 0; laddr = 0; lag = 0;
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    t_off;
    t_inv;
    t_sizes;
    t_buffer;
    t_linv;
    t_nc;
    t_region;
    end_sim;
  end
endmodule // direct_mapped_instruction_cache_bench
